// ### hw/fels_pkg.sv
package fels_pkg;

    // flash geometry
    localparam int FELS_PAGE_BYTES    = 512;
    localparam int FELS_PAGE_WORDS    = FELS_PAGE_BYTES / 4;
    localparam int FELS_FLASH_BYTES   = 524288;
    localparam int FELS_TOTAL_PAGES   = FELS_FLASH_BYTES / FELS_PAGE_BYTES;
    localparam int FELS_SMALL_PAGES   = 16;
    localparam int FELS_MID_PAGES     = 96;
    localparam int FELS_SECTOR_PAGES  = 128;
    localparam int FELS_LOCK_BITS     = 64;
    localparam int FELS_REGION_BYTES  = 8192;
    localparam int FELS_REGION_PAGES  = FELS_REGION_BYTES / FELS_PAGE_BYTES;
    localparam int FELS_PGROUP_BASE   = 4;

    // register byte offsets
    localparam logic [11:0] FELS_OFS_MODE    = 12'h000;
    localparam logic [11:0] FELS_OFS_CMD     = 12'h004;
    localparam logic [11:0] FELS_OFS_STATUS  = 12'h008;
    localparam logic [11:0] FELS_OFS_RESULT  = 12'h00c;
    localparam logic [11:0] FELS_OFS_RADDR   = 12'h010;
    localparam logic [11:0] FELS_OFS_RDATA   = 12'h014;
    localparam logic [11:0] FELS_OFS_LOCK_LO = 12'h018;
    localparam logic [11:0] FELS_OFS_LOCK_HI = 12'h01c;
    localparam logic [11:0] FELS_OFS_BUF     = 12'h200;

    // field positions
    localparam int FELS_CMD_CODE_LSB  = 0;
    localparam int FELS_CMD_ARG_LSB   = 8;
    localparam int FELS_ST_READY      = 0;
    localparam int FELS_ST_CMD_ERR    = 1;
    localparam int FELS_ST_LOCK_ERR   = 2;
    localparam int FELS_ST_RD_READY   = 3;
    localparam int FELS_ST_SIG_RD     = 4;

    // reset values
    localparam logic [3:0] FELS_FWS_RST = 4'h0;

    // command codes
    localparam logic [7:0] FELS_CMD_GET_DESC  = 8'h00;
    localparam logic [7:0] FELS_CMD_EWP       = 8'h03;
    localparam logic [7:0] FELS_CMD_ERASE_WRITE_PAGE_LOCK_CMD      = 8'h04;
    localparam logic [7:0] FELS_CMD_FULL      = 8'h05;
    localparam logic [7:0] FELS_CMD_PGROUP    = 8'h07;
    localparam logic [7:0] FELS_CMD_SET_LOCK  = 8'h08;
    localparam logic [7:0] FELS_CMD_CLR_LOCK  = 8'h09;
    localparam logic [7:0] FELS_CMD_SECTOR    = 8'h11;
    localparam logic [7:0] FELS_CMD_SIG_WRITE = 8'h12;
    localparam logic [7:0] FELS_CMD_SIG_ERASE = 8'h13;
    localparam logic [7:0] FELS_CMD_SIG_RD_ON = 8'h14;
    localparam logic [7:0] FELS_CMD_SIG_RD_OFF = 8'h15;

    localparam logic [2:0] FELS_DESC_LAST = 3'h4;

    typedef enum logic [2:0] {
        FELS_IDLE,
        FELS_ERASE_WAIT,
        FELS_PROG,
        FELS_PROG_WAIT,
        FELS_READ
    } fels_state_e;

    // request toward the flash array
    typedef struct packed {
        logic        erase;
        logic        wr;
        logic        commit;
        logic        read;
        logic        sig;
        logic [9:0]  first_page;
        logic [10:0] page_count;
        logic [6:0]  word;
        logic [31:0] wdata;
    } fels_arr_req_s;

endpackage : fels_pkg

// ### hw/fels_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - pages are 512 bytes, page commands page-granular
// - first sector: two 16-page, one 96-page
// - later sectors hold 128 pages each
// - whole array is 512 KB
// - small sectors accept erase-write and erase-write-lock
// - sector erase: any page selects whole sector
// - small sector group erase: 4 or 8 pages
// - large sectors group erase: 8, 16, 32 pages
// - full erase clears whole main array
// - signature page only via dedicated commands
// - erase pin never touches signature page
// - 64 lock bits, 8 KB region each
// - locked target aborts command, raises flag
// - set-lock protects, clear-lock unprotects region
// - erase pin clears all lock bits
// - descriptor command reports flash geometry
// - serve array reads, accept buffer writes
// - command interface on peripheral bus clock
module fels_sequencer
    import fels_pkg::*;
#(
    parameter logic [31:0] DESC_ID = 32'h0000_5a5a  // arbitrary identity value
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [11:0]   wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic               wb_ack_o,
    output logic [31:0]        wb_dat_o,
    input  wire logic          erase_pin_i,
    input  wire logic          arr_done_i,
    input  wire logic [31:0]   arr_rdata_i,
    output fels_arr_req_s      arr_req_o,
    output logic               cmd_err_o,
    output logic               lock_err_o
);

    if (FELS_LOCK_BITS * FELS_REGION_PAGES != FELS_TOTAL_PAGES) begin : g_chk
        $error("lock regions do not tile the array");
    end

    typedef struct packed {
        fels_state_e   st;
        logic          ack;
        logic [31:0]   rdata;
        logic [63:0]   locks;
        logic          cmd_err;
        logic          lock_err;
        logic [3:0]    fws;
        logic          sig_rd;
        logic [2:0]    desc_idx;
        logic          then_prog;
        logic          lock_pend;
        logic [5:0]    lock_region;
        logic [7:0]    wcnt;
        logic [31:0]   rd_data;
        logic          rd_ready;
        logic          epin_q;
        logic          epin_pend;
        fels_arr_req_s arr;
    } fels_regs_s;

    fels_regs_s  s_reg;
    fels_regs_s  s_next;
    logic [31:0] buf_mem [FELS_PAGE_WORDS];

    logic        req;
    logic        wr_go;
    logic        buf_we;
    logic [7:0]  code;
    logic [15:0] arg;
    logic [9:0]  dec_pg;
    logic [9:0]  sec_start;
    logic [10:0] sec_size;
    logic [10:0] grp;
    logic [9:0]  dec_start;
    logic [10:0] dec_count;
    logic [9:0]  dec_last;
    logic        dec_bad;
    logic [63:0] in_range;
    logic        lock_hit;
    logic [31:0] desc_word;

    assign req    = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign wr_go  = req & wb_we_i;
    assign buf_we = wr_go & (wb_adr_i[11:9] == FELS_OFS_BUF[11:9]);
    assign code   = wb_dat_i[FELS_CMD_CODE_LSB +: 8];
    assign arg    = wb_dat_i[FELS_CMD_ARG_LSB +: 16];

    // argument decode against the sector that holds the page
    always_comb begin
        dec_pg = (code == FELS_CMD_PGROUP) ? arg[11:2] : arg[9:0];
        if (dec_pg < 10'(FELS_SMALL_PAGES)) begin
            sec_start = 10'h000;
            sec_size  = 11'(FELS_SMALL_PAGES);
        end else if (dec_pg < 10'(2 * FELS_SMALL_PAGES)) begin
            sec_start = 10'(FELS_SMALL_PAGES);
            sec_size  = 11'(FELS_SMALL_PAGES);
        end else if (dec_pg < 10'(FELS_SECTOR_PAGES)) begin
            sec_start = 10'(2 * FELS_SMALL_PAGES);
            sec_size  = 11'(FELS_MID_PAGES);
        end else begin
            sec_start = {dec_pg[9:7], 7'h00};
            sec_size  = 11'(FELS_SECTOR_PAGES);
        end
        grp       = 11'(FELS_PGROUP_BASE) << arg[1:0];
        dec_bad   = 1'b0;
        dec_start = dec_pg;
        dec_count = 11'h001;
        case (code)
            FELS_CMD_SECTOR: begin
                dec_start = sec_start;
                dec_count = sec_size;
            end
            FELS_CMD_PGROUP: begin
                // small: 4 or 8 pages; large: 8, 16 or 32 pages
                if (sec_size == 11'(FELS_SMALL_PAGES)) begin
                    dec_bad = arg[1];
                end else begin
                    dec_bad = (arg[1:0] == 2'h0);
                end
                dec_start = dec_pg & ~(grp[9:0] - 10'h001);
                dec_count = grp;
            end
            FELS_CMD_FULL: begin
                dec_start = 10'h000;
                dec_count = 11'(FELS_TOTAL_PAGES);
            end
            default: begin
                dec_start = dec_pg;
                dec_count = 11'h001;
            end
        endcase
        // 10-bit wrap makes the full-array case end at the last page
        dec_last = 10'(dec_start + dec_count[9:0] - 10'h001);
    end

    for (genvar i = 0; i < FELS_LOCK_BITS; i++) begin : g_rng
        localparam logic [5:0] IDX = 6'(i);
        assign in_range[i] = (IDX >= dec_start[9:4]) && (IDX <= dec_last[9:4]);
    end

    assign lock_hit = |(s_reg.locks & in_range);

    always_comb begin
        case (s_reg.desc_idx)
            3'h0:    desc_word = DESC_ID;
            3'h1:    desc_word = 32'(FELS_FLASH_BYTES);
            3'h2:    desc_word = 32'(FELS_PAGE_BYTES);
            3'h3:    desc_word = 32'(FELS_LOCK_BITS);
            default: desc_word = 32'(FELS_REGION_BYTES);
        endcase
    end

    always_comb begin
        s_next            = s_reg;
        s_next.ack        = req;
        s_next.arr.erase  = 1'b0;
        s_next.arr.wr     = 1'b0;
        s_next.arr.commit = 1'b0;
        s_next.arr.read   = 1'b0;

        if (req && !wb_we_i) begin
            case (wb_adr_i)
                FELS_OFS_MODE:    s_next.rdata = {28'h0000000, s_reg.fws};
                FELS_OFS_STATUS:  s_next.rdata = {27'h0000000, s_reg.sig_rd, s_reg.rd_ready,
                                                  s_reg.lock_err, s_reg.cmd_err,
                                                  s_reg.st == FELS_IDLE};
                FELS_OFS_RESULT: begin
                    s_next.rdata    = desc_word;
                    s_next.desc_idx = (s_reg.desc_idx == FELS_DESC_LAST) ? 3'h0
                                      : 3'(s_reg.desc_idx + 3'h1);
                end
                FELS_OFS_RDATA:   s_next.rdata = s_reg.rd_data;
                FELS_OFS_LOCK_LO: s_next.rdata = s_reg.locks[31:0];
                FELS_OFS_LOCK_HI: s_next.rdata = s_reg.locks[63:32];
                default:          s_next.rdata = 32'h00000000;
            endcase
        end

        if (wr_go && wb_adr_i == FELS_OFS_MODE) begin
            s_next.fws = wb_dat_i[3:0];
        end

        if (wr_go && s_reg.st != FELS_IDLE &&
            (wb_adr_i == FELS_OFS_CMD || wb_adr_i == FELS_OFS_RADDR)) begin
            s_next.cmd_err = 1'b1;
        end

        case (s_reg.st)
            FELS_IDLE: begin
                if (wr_go && wb_adr_i == FELS_OFS_CMD) begin
                    s_next.cmd_err   = 1'b0;
                    s_next.lock_err  = 1'b0;
                    s_next.then_prog = 1'b0;
                    s_next.lock_pend = 1'b0;
                    s_next.arr.first_page = dec_start;
                    s_next.arr.page_count = dec_count;
                    s_next.arr.sig   = 1'b0;
                    case (code)
                        FELS_CMD_GET_DESC: s_next.desc_idx = 3'h0;
                        FELS_CMD_EWP, FELS_CMD_ERASE_WRITE_PAGE_LOCK_CMD, FELS_CMD_SECTOR,
                        FELS_CMD_PGROUP, FELS_CMD_FULL: begin
                            if (dec_bad) begin
                                s_next.cmd_err = 1'b1;
                            end else if (lock_hit) begin
                                s_next.lock_err = 1'b1;
                            end else begin
                                s_next.arr.erase   = 1'b1;
                                s_next.then_prog   = (code == FELS_CMD_EWP) ||
                                                     (code == FELS_CMD_ERASE_WRITE_PAGE_LOCK_CMD);
                                s_next.lock_pend   = (code == FELS_CMD_ERASE_WRITE_PAGE_LOCK_CMD);
                                s_next.lock_region = dec_start[9:4];
                                s_next.st          = FELS_ERASE_WAIT;
                            end
                        end
                        FELS_CMD_SIG_ERASE, FELS_CMD_SIG_WRITE: begin
                            // signature page sits outside the lock map
                            s_next.arr.sig        = 1'b1;
                            s_next.arr.first_page = 10'h000;
                            s_next.arr.page_count = 11'h001;
                            s_next.arr.erase      = 1'b1;
                            s_next.then_prog      = (code == FELS_CMD_SIG_WRITE);
                            s_next.st             = FELS_ERASE_WAIT;
                        end
                        FELS_CMD_SIG_RD_ON:  s_next.sig_rd = 1'b1;
                        FELS_CMD_SIG_RD_OFF: s_next.sig_rd = 1'b0;
                        FELS_CMD_SET_LOCK:   s_next.locks[dec_pg[9:4]] = 1'b1;
                        FELS_CMD_CLR_LOCK:   s_next.locks[dec_pg[9:4]] = 1'b0;
                        default:             s_next.cmd_err = 1'b1;
                    endcase
                end else if (wr_go && wb_adr_i == FELS_OFS_RADDR) begin
                    s_next.arr.read       = 1'b1;
                    s_next.arr.sig        = s_reg.sig_rd;
                    s_next.arr.first_page = wb_dat_i[16:7];
                    s_next.arr.word       = wb_dat_i[6:0];
                    s_next.rd_ready       = 1'b0;
                    s_next.wcnt           = 8'h00;
                    s_next.st             = FELS_READ;
                end else if (s_reg.epin_pend) begin
                    // main array only, signature page left alone
                    s_next.epin_pend      = 1'b0;
                    s_next.arr.erase      = 1'b1;
                    s_next.arr.sig        = 1'b0;
                    s_next.arr.first_page = 10'h000;
                    s_next.arr.page_count = 11'(FELS_TOTAL_PAGES);
                    s_next.then_prog      = 1'b0;
                    s_next.lock_pend      = 1'b0;
                    s_next.st             = FELS_ERASE_WAIT;
                end
            end
            FELS_ERASE_WAIT: begin
                if (arr_done_i) begin
                    s_next.wcnt = 8'h00;
                    s_next.st   = s_reg.then_prog ? FELS_PROG : FELS_IDLE;
                end
            end
            FELS_PROG: begin
                s_next.arr.wr    = 1'b1;
                s_next.arr.word  = s_reg.wcnt[6:0];
                s_next.arr.wdata = buf_mem[s_reg.wcnt[6:0]];
                s_next.wcnt      = 8'(s_reg.wcnt + 8'h01);
                if (s_reg.wcnt == 8'(FELS_PAGE_WORDS - 1)) begin
                    s_next.st = FELS_PROG_WAIT;
                end
            end
            FELS_PROG_WAIT: begin
                s_next.arr.commit = (s_reg.wcnt == 8'(FELS_PAGE_WORDS));
                s_next.wcnt       = 8'h00;
                if (arr_done_i) begin
                    if (s_reg.lock_pend) begin
                        s_next.locks[s_reg.lock_region] = 1'b1;
                    end
                    s_next.lock_pend = 1'b0;
                    s_next.st        = FELS_IDLE;
                end
            end
            FELS_READ: begin
                // array data is taken fws+1 cycles after the read strobe
                if (s_reg.wcnt == 8'(s_reg.fws) + 8'h01) begin
                    s_next.rd_data  = arr_rdata_i;
                    s_next.rd_ready = 1'b1;
                    s_next.st       = FELS_IDLE;
                end else begin
                    s_next.wcnt = 8'(s_reg.wcnt + 8'h01);
                end
            end
            default: s_next.st = FELS_IDLE;
        endcase

        // pin effects last so they win over software
        s_next.epin_q = erase_pin_i;
        if (erase_pin_i && !s_reg.epin_q) begin
            s_next.epin_pend = 1'b1;
        end
        if (erase_pin_i) begin
            s_next.locks = 64'h0000000000000000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg     <= '0;
            s_reg.fws <= FELS_FWS_RST;
        end else begin
            s_reg <= s_next;
        end
        // buffer content carries no control meaning, so it skips reset
        if (buf_we) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    buf_mem[wb_adr_i[8:2]][8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end
    end

    assign wb_ack_o   = s_reg.ack;
    assign wb_dat_o   = s_reg.rdata;
    assign arr_req_o  = s_reg.arr;
    assign cmd_err_o  = s_reg.cmd_err;
    assign lock_err_o = s_reg.lock_err;

endmodule : fels_sequencer

`default_nettype wire

// ### tb/fels_props.sv
`timescale 1ns/100ps
`default_nettype none
module fels_props
    import fels_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          rst_i,
    input wire logic          wb_cyc_i,
    input wire logic          wb_stb_i,
    input wire logic          wb_ack_o,
    input wire fels_arr_req_s arr_req_o,
    input wire logic          lock_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_commit_after_last: assert property (arr_req_o.commit |->
        $past(arr_req_o.wr) && $past(arr_req_o.word) == 7'h7f)
        else $error("commit not after word 127");
    a_wr_starts_zero: assert property ($rose(arr_req_o.wr) |-> arr_req_o.word == 7'h00)
        else $error("write burst not from word 0");
    a_wr_word_step: assert property (arr_req_o.wr && $past(arr_req_o.wr) |->
        arr_req_o.word == $past(arr_req_o.word) + 7'h01)
        else $error("write burst skips a word");
    a_erase_single: assert property (arr_req_o.erase |=> !arr_req_o.erase [*3])
        else $error("erase pulses overlap");
    a_group_aligned: assert property (arr_req_o.erase && arr_req_o.page_count inside {4, 8, 16, 32, 128}
        |-> (arr_req_o.first_page & (arr_req_o.page_count[9:0] - 10'h1)) == 10'h0)
        else $error("erase span not aligned");
    a_span_fits: assert property (arr_req_o.erase |->
        32'(arr_req_o.first_page) + 32'(arr_req_o.page_count) <= 1024)
        else $error("erase beyond array end");
    a_small_sizes: assert property (arr_req_o.erase && !arr_req_o.sig && arr_req_o.first_page < 10'd32
        |-> arr_req_o.page_count inside {1, 4, 8, 16, 1024})
        else $error("bad erase size in small sector");
    a_big_sector: assert property (arr_req_o.erase && arr_req_o.first_page >= 10'd128 &&
        arr_req_o.page_count > 11'd32 |-> arr_req_o.page_count == 11'd128)
        else $error("bad sector size");
    c_erase: cover property (arr_req_o.erase);
    c_commit: cover property (arr_req_o.commit);
    c_lock_err: cover property ($rose(lock_err_o));
endmodule : fels_props
`default_nettype wire

// ### tb/fels_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fels_flash_model
    import fels_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire fels_arr_req_s arr_req_i,
    input  wire logic [7:0]    lat_i,
    input  wire logic [3:0]    fws_i,
    output logic               done_o,
    output logic [31:0]        rdata_o
);
    int busy_cnt;
    int rd_cnt;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        // data bus not driven: toggles so stale values never match
        rdata_o <= ~rdata_o;
        if (rd_cnt > 0) begin
            rd_cnt <= rd_cnt - 1;
            rdata_o <= rdata_o;
        end
        if (arr_req_i.read) begin
            rd_cnt <= 32'(fws_i) + 3;
            rdata_o <= {arr_req_i.sig, 4'h0, arr_req_i.first_page, 10'h0, arr_req_i.word};
        end
        if (busy_cnt == 1) done_o <= 1'b1;
        if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
        if (arr_req_i.erase || arr_req_i.commit) busy_cnt <= 32'(lat_i) + 1;
        if (rst_i) begin
            busy_cnt <= 0;
            rd_cnt <= 0;
            rdata_o <= 32'h0;
        end
    end
endmodule : fels_flash_model
`default_nettype wire

// ### tb/tb_fels_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fels_sequencer;
    import fels_pkg::*;
    localparam logic [31:0] D_ID = 32'h0000_3c3c;  // arbitrary identity value
    logic          clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, erase_pin_i;
    logic          arr_done_i, cmd_err_o, lock_err_o, e_sig;
    logic [11:0]   wb_adr_i;
    logic [3:0]    wb_sel_i, fws;
    logic [31:0]   wb_dat_i, wb_dat_o, arr_rdata_i, q, seed, bufm [128];
    logic [7:0]    lat;
    logic [9:0]    e_first;
    logic [10:0]   e_cnt;
    fels_arr_req_s arr_req_o;
    int            n_fail, cmp_count, n_erase, n_wr, n_commit, k;
    int tc [9][4] = '{'{7, 20, 4, 4}, '{7, 53, 8, 8}, '{7, 801, 200, 8}, '{7, 802, 192, 16},
        '{7, 803, 192, 32}, '{17, 3, 0, 16}, '{17, 20, 16, 16}, '{17, 50, 32, 96}, '{5, 0, 0, 1024}};
    int desc [5] = '{int'(D_ID), 524288, 512, 64, 8192};

    fels_sequencer #(.DESC_ID(D_ID)) u_fels_sequencer (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .erase_pin_i(erase_pin_i), .arr_done_i(arr_done_i), .arr_rdata_i(arr_rdata_i),
        .arr_req_o(arr_req_o), .cmd_err_o(cmd_err_o), .lock_err_o(lock_err_o));
    fels_flash_model u_fels_flash_model (.clk_i(clk_i), .rst_i(rst_i), .arr_req_i(arr_req_o),
        .lat_i(lat), .fws_i(fws), .done_o(arr_done_i), .rdata_o(arr_rdata_i));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // hold the request until ack is sampled high at a rising edge
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic cmd(input int code, input int arg);
        wb(1'b1, FELS_OFS_CMD, {8'h0, arg[15:0], code[7:0]});
    endtask : cmd

    task automatic wait_idle;
        for (int i = 0; i < 400; i++) begin
            wb(1'b0, FELS_OFS_STATUS, 32'h0);
            if (q[FELS_ST_READY] === 1'b1) break;
        end
    endtask : wait_idle

    task automatic erase(input int code, input int arg, input int first, input int cnt);
        e_first = first[9:0];
        e_cnt = cnt[10:0];
        k = n_erase;
        cmd(code, arg);
        wait_idle();
        chk("erase count", 32'(k + 1), 32'(n_erase));
    endtask : erase

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    always @(negedge clk_i) begin
        if (!rst_i && arr_req_o.erase) begin
            n_erase++;
            chk("erase sig", 32'(e_sig), 32'(arr_req_o.sig));
            if (!e_sig) chk("erase first", 32'(e_first), 32'(arr_req_o.first_page));
            if (!e_sig) chk("erase pages", 32'(e_cnt), 32'(arr_req_o.page_count));
        end
        if (!rst_i && arr_req_o.wr) begin
            n_wr++;
            chk("page word", bufm[arr_req_o.word], arr_req_o.wdata);
        end
        if (!rst_i && arr_req_o.commit) n_commit++;
    end

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end

    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, erase_pin_i} = 5'b10000;
        {wb_adr_i, wb_sel_i, wb_dat_i, fws, lat, e_sig} = '0;
        seed = 32'hb748;
        wb_sel_i = 4'hf;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        cmd(0, 0);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, FELS_OFS_RESULT, 32'h0);
            chk("descriptor", desc[i], q);
        end
        wb(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h0, q);
        for (int i = 0; i < 9; i++) begin
            lat <= (i % 2 == 1) ? 8'd40 : 8'd1;
            erase(tc[i][0], tc[i][1], tc[i][2], tc[i][3]);
        end
        k = 128 + ({$random(seed)} % 896);
        erase(17, k, k & 32'h380, 128);
        for (int i = 2; i < 4; i++) begin
            k = n_erase;
            cmd(7, 20 + i);
            wait_idle();
            chk("bad group size", 32'h8000_0000, {cmd_err_o, 31'(n_erase - k)});
        end
        cmd(8, 40);
        wait_idle();
        wb(1'b0, FELS_OFS_LOCK_LO, 32'h0);
        chk("lock set", 32'h4, q);
        k = n_erase;
        cmd(17, 40);
        wait_idle();
        chk("locked erase", 32'h8000_0000, {lock_err_o, 31'(n_erase - k)});
        cmd(9, 40);
        wait_idle();
        wb(1'b0, FELS_OFS_LOCK_LO, 32'h0);
        chk("lock clear", 32'h0, q);
        lat <= 8'd60;
        e_first = 10'h0;
        e_cnt = 11'd1024;
        k = n_erase;
        cmd(5, 0);
        cmd(17, 300);
        chk("busy refused", 32'h1, 32'(cmd_err_o));
        wait_idle();
        chk("busy erases", 32'(k + 1), 32'(n_erase));
        wb(1'b1, FELS_OFS_MODE, 32'h2);
        fws <= 4'h2;
        wb(1'b1, FELS_OFS_RADDR, 32'h0485);
        for (int i = 0; i < 20 && q[FELS_ST_RD_READY] !== 1'b1; i++) wb(1'b0, FELS_OFS_STATUS, 32'h0);
        wb(1'b0, FELS_OFS_RDATA, 32'h0);
        chk("array read", {1'b0, 4'h0, 10'd9, 10'h0, 7'd5}, q);
        lat <= 8'd3;
        for (int i = 0; i < 128; i++) begin
            bufm[i] = $random(seed);
            wb(1'b1, FELS_OFS_BUF + 12'(i * 4), bufm[i]);
        end
        erase(3, 3, 3, 1);
        erase(4, 20, 20, 1);
        chk("burst", {16'd256, 16'd2}, {16'(n_wr), 16'(n_commit)});
        wb(1'b0, FELS_OFS_LOCK_LO, 32'h0);
        chk("write lock", 32'h2, q);
        e_sig = 1'b1;
        erase(19, 0, 0, 0);
        e_sig = 1'b0;
        k = n_erase;
        e_first = 10'h0;
        e_cnt = 11'd1024;
        erase_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        erase_pin_i <= 1'b0;
        wait_idle();
        chk("pin erase", 32'(k + 1), 32'(n_erase));
        wb(1'b0, FELS_OFS_LOCK_LO, 32'h0);
        chk("pin unlock", 32'h0, q);
        report_and_stop();
    end
endmodule : tb_fels_sequencer

bind fels_sequencer fels_props u_fels_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .arr_req_o(arr_req_o), .lock_err_o(lock_err_o));
`default_nettype wire
